//--- design/iosr_top.sv
`timescale 1ns/10ps
module iosr_top
  import iosr_pkg::*;
(
  input  wire logic                    i_core_clk,
  input  wire logic                    i_resetn,
  input  wire logic                    i_reg_rd,
  input  wire logic                    i_reg_wr,
  input  wire logic [ADDR_W-1:0]       i_reg_addr,
  input  wire logic [DATA_W-1:0]       i_reg_wdata,
  output logic      [DATA_W-1:0]       o_reg_rdata,
  output logic                         o_reg_rvalid,
  input  wire logic [NUM_CH-1:0]       i_input_compare,
  input  wire logic [NUM_CH*DEB_W-1:0] i_debounce_time,
  input  wire logic                    i_conv_valid,
  input  wire logic [1:0]              i_conv_channel,
  input  wire logic [DATA_W-1:0]       i_conv_data,
  input  wire logic                    i_diag_valid,
  input  wire logic [1:0]              i_diag_slot,
  input  wire logic [DATA_W-1:0]       i_diag_data,
  input  wire logic [NUM_CH*SEL_W-1:0] i_diag_source_select,
  output logic      [NUM_CH*SEL_W-1:0] o_diag_source,
  input  wire logic                    i_cal_refresh_done,
  input  wire logic                    i_cal_load_error,
  input  wire logic                    i_frame_check_error,
  input  wire logic                    i_clock_count_fault,
  input  wire logic                    i_converter_saturation_fault,
  input  wire logic                    i_converter_range_fault,
  input  wire logic                    i_analog_core_supply_fault,
  output logic                         o_alert
);

  function automatic logic [SEL_W-1:0] legal_source(input logic [SEL_W-1:0] code);
    legal_source = (code > SRC_LAST_LISTED) ? SRC_ANALOG_GND : code;
  endfunction

  logic [NUM_CH-1:0]       input_states;
  iosr_deb_state_t         deb_state [NUM_CH];
  logic [DEB_W-1:0]        deb_count [NUM_CH];
  logic [TICK_W-1:0]       tick_count;
  logic                    deb_tick;
  logic [DATA_W-1:0]       conv_results [NUM_CH];
  logic [DATA_W-1:0]       diag_results [NUM_CH];
  logic [DATA_W-1:0]       alert_flags;
  logic [DATA_W-1:0]       next_alert_flags;
  logic [DATA_W-1:0]       flag_set;
  logic [DATA_W-1:0]       flag_clear;
  logic [DATA_W-1:0]       next_rdata;
  logic                    early_access;

  // debounce time base; one enable pulse per tick keeps a single clock
  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      tick_count <= '0;
      deb_tick   <= 1'b0;
    end else if (tick_count == TICK_W'(DEB_TICK_CYCLES - 1)) begin
      tick_count <= '0;
      deb_tick   <= 1'b1;
    end else begin
      tick_count <= tick_count + 1'b1;
      deb_tick   <= 1'b0;
    end
  end

  // a change must persist for the programmed number of ticks; a glitch restarts it
  for (genvar ch = 0; ch < NUM_CH; ch++) begin : g_deb
    always_ff @(posedge i_core_clk or negedge i_resetn) begin
      if (!i_resetn) begin
        deb_state[ch]    <= IOSR_DEB_STABLE;
        deb_count[ch]    <= '0;
        input_states[ch] <= 1'b0;
      end else begin
        case (deb_state[ch])
          IOSR_DEB_STABLE: begin
            deb_count[ch] <= '0;
            if (i_input_compare[ch] != input_states[ch]) begin
              if (i_debounce_time[ch*DEB_W +: DEB_W] == '0) begin
                input_states[ch] <= i_input_compare[ch];
              end else begin
                deb_state[ch] <= IOSR_DEB_COUNTING;
              end
            end
          end
          IOSR_DEB_COUNTING: begin
            if (i_input_compare[ch] == input_states[ch]) begin
              deb_state[ch] <= IOSR_DEB_STABLE;
            end else if (deb_tick) begin
              if (deb_count[ch] + 1'b1 >= i_debounce_time[ch*DEB_W +: DEB_W]) begin
                input_states[ch] <= i_input_compare[ch];
                deb_state[ch]    <= IOSR_DEB_STABLE;
              end
              deb_count[ch] <= deb_count[ch] + 1'b1;
            end
          end
          default: begin
            deb_state[ch] <= IOSR_DEB_STABLE;
          end
        endcase
      end
    end
  end

  // results only move on converter strobes; bus writes never reach them
  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      for (int i = 0; i < NUM_CH; i++) begin
        conv_results[i] <= RESULT_RESET;
      end
    end else if (i_conv_valid) begin
      conv_results[i_conv_channel] <= i_conv_data;
    end
  end

  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      for (int i = 0; i < NUM_CH; i++) begin
        diag_results[i] <= RESULT_RESET;
      end
    end else if (i_diag_valid) begin
      diag_results[i_diag_slot] <= i_diag_data;
    end
  end

  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_diag_source <= '0;
    end else begin
      for (int i = 0; i < NUM_CH; i++) begin
        o_diag_source[i*SEL_W +: SEL_W] <= legal_source(i_diag_source_select[i*SEL_W +: SEL_W]);
      end
    end
  end

  // the host should hold off until refresh completes; if it does not, flag it
  assign early_access = (i_reg_rd || i_reg_wr) && !i_cal_refresh_done;

  always_comb begin
    flag_set = '0;
    flag_set[BIT_CAL_STORE_FAULT] = i_cal_load_error || early_access;
    flag_set[BIT_FRAME_CHECK]     = i_frame_check_error;
    flag_set[BIT_CLOCK_COUNT]     = i_clock_count_fault;
    flag_set[BIT_CONV_SAT]        = i_converter_saturation_fault;
    flag_set[BIT_CONV_RANGE]      = i_converter_range_fault;
    flag_set[BIT_ANALOG_SUPPLY]   = i_analog_core_supply_fault;
    flag_clear = (i_reg_wr && i_reg_addr == ADDR_ALERT_FLAGS) ? i_reg_wdata : '0;
    // set wins, so a persisting load error holds bit 14 against clears
    next_alert_flags = ((alert_flags & ~flag_clear) | flag_set) & ALERT_IMPL_MASK;
  end

  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      alert_flags <= ALERT_RESET;
      o_alert     <= 1'b1;
    end else begin
      alert_flags <= next_alert_flags;
      // masks are not modelled, so every implemented flag drives the alert
      o_alert     <= |next_alert_flags;
    end
  end

  always_comb begin
    next_rdata = '0;
    if (i_reg_addr == ADDR_INPUT_STATES) begin
      next_rdata[NUM_CH-1:0] = input_states;
    end else if (i_reg_addr >= ADDR_CONV_BASE && i_reg_addr <= ADDR_CONV_LAST) begin
      next_rdata = conv_results[2'(i_reg_addr - ADDR_CONV_BASE)];
    end else if (i_reg_addr >= ADDR_DIAG_BASE && i_reg_addr <= ADDR_DIAG_LAST) begin
      next_rdata = diag_results[2'(i_reg_addr - ADDR_DIAG_BASE)];
    end else if (i_reg_addr == ADDR_ALERT_FLAGS) begin
      next_rdata = alert_flags;
    end
  end

  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_reg_rdata  <= '0;
      o_reg_rvalid <= 1'b0;
    end else begin
      o_reg_rvalid <= i_reg_rd;
      if (i_reg_rd) begin
        o_reg_rdata <= next_rdata;
      end
    end
  end

  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_resetn);

  sequence s_clear_write;
    i_reg_wr && i_reg_addr == ADDR_ALERT_FLAGS && i_reg_wdata[BIT_RESET_SEEN];
  endsequence

  // a slot-0 load, a quiet gap and then a read must hand back the loaded word
  sequence s_conv_load0;
    i_conv_valid && i_conv_channel == 2'h0;
  endsequence

  sequence s_conv_read0;
    i_reg_rd && i_reg_addr == ADDR_CONV_BASE && !i_conv_valid;
  endsequence

  sequence s_diag_load0;
    i_diag_valid && i_diag_slot == 2'h0;
  endsequence

  sequence s_diag_read0;
    i_reg_rd && i_reg_addr == ADDR_DIAG_BASE && !i_diag_valid;
  endsequence

  a_reset_seen_clear: assert property (
    s_clear_write ##1 1'b1 |-> !alert_flags[BIT_RESET_SEEN])
    else $error("reset flag not cleared by write of one");
  a_reset_seen_hold: assert property (
    alert_flags[BIT_RESET_SEEN] && !(i_reg_wr && i_reg_addr == ADDR_ALERT_FLAGS)
      |=> alert_flags[BIT_RESET_SEEN])
    else $error("reset flag dropped without a clear");
  a_cal_persist: assert property (
    i_cal_load_error |=> alert_flags[BIT_CAL_STORE_FAULT])
    else $error("calibration fault not held while error persists");
  a_early_access: assert property (
    (i_reg_rd || i_reg_wr) && !i_cal_refresh_done |=> alert_flags[BIT_CAL_STORE_FAULT])
    else $error("early access did not flag calibration fault");
  a_cal_clear: assert property (
    i_reg_wr && i_reg_addr == ADDR_ALERT_FLAGS && i_reg_wdata[BIT_CAL_STORE_FAULT]
      && i_cal_refresh_done && !i_cal_load_error |=> !alert_flags[BIT_CAL_STORE_FAULT])
    else $error("calibration fault not cleared by write of one");
  a_frame_fault: assert property (
    i_frame_check_error |=> alert_flags[BIT_FRAME_CHECK] && o_alert)
    else $error("frame check fault not flagged");
  a_frame_clear: assert property (
    i_reg_wr && i_reg_addr == ADDR_ALERT_FLAGS && i_reg_wdata[BIT_FRAME_CHECK]
      && !i_frame_check_error |=> !alert_flags[BIT_FRAME_CHECK])
    else $error("frame check fault not cleared by write of one");
  a_clock_count_fault: assert property (
    i_clock_count_fault |=> alert_flags[BIT_CLOCK_COUNT] && o_alert)
    else $error("clock count fault not flagged");
  a_saturation_fault: assert property (
    i_converter_saturation_fault |=> alert_flags[BIT_CONV_SAT] && o_alert)
    else $error("converter saturation fault not flagged");
  a_range_fault: assert property (
    i_converter_range_fault |=> alert_flags[BIT_CONV_RANGE] && o_alert)
    else $error("converter range fault not flagged");
  a_reset_state: assert property (
    disable iff (1'b0) $rose(i_resetn) |-> alert_flags == ALERT_RESET && o_alert)
    else $error("reset did not raise the reset-seen flag and alert");
  a_supply_fault: assert property (
    i_analog_core_supply_fault |=> alert_flags[BIT_ANALOG_SUPPLY])
    else $error("supply fault not flagged");
  a_zero_write_keeps: assert property (
    i_reg_wr && i_reg_addr == ADDR_ALERT_FLAGS && i_reg_wdata == '0
      |=> (alert_flags & $past(alert_flags)) == $past(alert_flags))
    else $error("zero write changed alert flags");
  a_input_reserved: assert property (
    i_reg_rd && i_reg_addr == ADDR_INPUT_STATES
      |=> o_reg_rvalid && o_reg_rdata[DATA_W-1:NUM_CH] == '0 && o_reg_rdata[NUM_CH-1:0] == $past(input_states))
    else $error("input state readback wrong");
  a_conv_readback: assert property (
    s_conv_load0 ##1 !i_conv_valid ##1 s_conv_read0
      |=> o_reg_rdata == $past(i_conv_data, 3))
    else $error("conversion result readback wrong");
  a_diag_readback: assert property (
    s_diag_load0 ##1 (!i_diag_valid) [*3] ##1 s_diag_read0
      |=> o_reg_rdata == $past(i_diag_data, 5))
    else $error("diagnostic result readback wrong");
  a_result_write_ignored: assert property (
    i_reg_wr && i_reg_addr == ADDR_CONV_BASE && !i_conv_valid
      |=> conv_results[0] == $past(conv_results[0]))
    else $error("bus write changed a conversion result");
  a_unmapped_zero: assert property (
    i_reg_rd && (i_reg_addr < ADDR_INPUT_STATES || i_reg_addr > ADDR_ALERT_FLAGS)
      |=> o_reg_rvalid && o_reg_rdata == '0)
    else $error("unmapped read returned nonzero data");
  a_diag_source: assert property (
    i_diag_source_select[SEL_W-1:0] == 4'hF |=> o_diag_source[SEL_W-1:0] == SRC_ANALOG_GND)
    else $error("unlisted source code not mapped to ground");
  a_deb_filter: assert property (
    i_debounce_time[DEB_W-1:0] != '0 && $changed(i_input_compare[0]) && i_input_compare[0] != input_states[0]
      |=> input_states[0] == $past(input_states[0]))
    else $error("input passed without debounce");
  a_deb_bypass: assert property (
    i_debounce_time[DEB_W-1:0] == '0 && deb_state[0] == IOSR_DEB_STABLE
      && i_input_compare[0] != input_states[0]
      |=> input_states[0] == $past(i_input_compare[0]))
    else $error("zero debounce time did not pass input at once");
  a_source_pass: assert property (
    i_diag_source_select[SEL_W-1:0] <= SRC_LAST_LISTED
      |=> o_diag_source[SEL_W-1:0] == $past(i_diag_source_select[SEL_W-1:0]))
    else $error("listed source code not passed through");

endmodule // iosr_top

//--- pkg/iosr_pkg.sv
package iosr_pkg;
  localparam int unsigned NUM_CH        = 4;
  localparam int unsigned DATA_W        = 16;
  localparam int unsigned ADDR_W        = 8;
  localparam int unsigned SEL_W         = 4;
  localparam int unsigned DEB_W         = 4;

  localparam logic [ADDR_W-1:0] ADDR_INPUT_STATES = 8'h25;
  localparam logic [ADDR_W-1:0] ADDR_CONV_BASE    = 8'h26;
  localparam logic [ADDR_W-1:0] ADDR_CONV_LAST    = 8'h29;
  localparam logic [ADDR_W-1:0] ADDR_DIAG_BASE    = 8'h2A;
  localparam logic [ADDR_W-1:0] ADDR_DIAG_LAST    = 8'h2D;
  localparam logic [ADDR_W-1:0] ADDR_ALERT_FLAGS  = 8'h2E;

  localparam logic [DATA_W-1:0] RESULT_RESET      = 16'h0000;
  localparam logic [DATA_W-1:0] ALERT_RESET       = 16'h8000;
  localparam logic [DATA_W-1:0] ALERT_IMPL_MASK   = 16'hFE00;

  localparam int unsigned BIT_RESET_SEEN      = 15;
  localparam int unsigned BIT_CAL_STORE_FAULT = 14;
  localparam int unsigned BIT_FRAME_CHECK     = 13;
  localparam int unsigned BIT_CLOCK_COUNT     = 12;
  localparam int unsigned BIT_CONV_SAT        = 11;
  localparam int unsigned BIT_CONV_RANGE      = 10;
  localparam int unsigned BIT_ANALOG_SUPPLY   = 9;

  localparam logic [SEL_W-1:0] SRC_ANALOG_GND  = 4'h0;
  localparam logic [SEL_W-1:0] SRC_LAST_LISTED = 4'hE;

  localparam int unsigned CLK_PERIOD_PS    = 4000;
  localparam int unsigned DEB_TICK_NS      = 1000;
  localparam int unsigned DEB_TICK_CYCLES  = (DEB_TICK_NS * 1000) / CLK_PERIOD_PS;
  localparam int unsigned TICK_W           = 8;

  typedef enum logic [1:0] {
    IOSR_DEB_STABLE,
    IOSR_DEB_COUNTING
  } iosr_deb_state_t;
endpackage

//--- verif/iosr_host_model.sv
`timescale 1ns/10ps
module iosr_host_model
  import iosr_pkg::*;
(
  input  wire logic              i_core_clk,
  input  wire logic              i_cal_refresh_done,
  input  wire logic [DATA_W-1:0] i_reg_rdata,
  input  wire logic              i_reg_rvalid,
  output logic                   o_reg_rd,
  output logic                   o_reg_wr,
  output logic      [ADDR_W-1:0] o_reg_addr,
  output logic      [DATA_W-1:0] o_reg_wdata
);
  logic early_ok = 1'b0;
  initial begin
    o_reg_rd    = 1'b0;
    o_reg_wr    = 1'b0;
    o_reg_addr  = 8'h00;
    o_reg_wdata = 16'h0000;
  end
  // a gap cycle between accesses keeps each strobe to one change per time step
  task automatic access(input logic wr, input logic [ADDR_W-1:0] a,
                        input logic [DATA_W-1:0] d, output logic [DATA_W-1:0] q,
                        output logic v);
    @(negedge i_core_clk);
    while (!i_cal_refresh_done && !early_ok) @(negedge i_core_clk);
    o_reg_wr    = wr;
    o_reg_rd    = !wr;
    o_reg_addr  = a;
    o_reg_wdata = d;
    @(negedge i_core_clk);
    q           = i_reg_rdata;
    v           = i_reg_rvalid;
    o_reg_rd    = 1'b0;
    o_reg_wr    = 1'b0;
    // idle lines wander so a stale address is never relied on
    o_reg_addr  = ~a;
    o_reg_wdata = ~d;
  endtask
endmodule // iosr_host_model

//--- verif/tb.sv
`timescale 1ns/10ps
module tb;
  import iosr_pkg::*;
  logic i_core_clk = 1'b0;
  logic i_resetn   = 1'b0;
  logic reg_rd, reg_wr, rvalid, cv, dv, cal_done, cal_err, alert;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wdata, rdata, cdat, ddat, deb, dsel, dsrc;
  logic [1:0]        cch, dslot;
  logic [3:0]        cmp;
  logic [4:0]        faults;
  int alert_m, din_m, fail_count, checks_done;
  int conv_m[4], diag_m[4];

  always #2 i_core_clk = ~i_core_clk;

  iosr_host_model host (.i_core_clk(i_core_clk), .i_cal_refresh_done(cal_done),
    .i_reg_rdata(rdata), .i_reg_rvalid(rvalid), .o_reg_rd(reg_rd), .o_reg_wr(reg_wr),
    .o_reg_addr(addr), .o_reg_wdata(wdata));

  iosr_top uut (.i_core_clk(i_core_clk), .i_resetn(i_resetn), .i_reg_rd(reg_rd),
    .i_reg_wr(reg_wr), .i_reg_addr(addr), .i_reg_wdata(wdata), .o_reg_rdata(rdata),
    .o_reg_rvalid(rvalid), .i_input_compare(cmp), .i_debounce_time(deb),
    .i_conv_valid(cv), .i_conv_channel(cch), .i_conv_data(cdat), .i_diag_valid(dv),
    .i_diag_slot(dslot), .i_diag_data(ddat), .i_diag_source_select(dsel),
    .o_diag_source(dsrc), .i_cal_refresh_done(cal_done), .i_cal_load_error(cal_err),
    .i_frame_check_error(faults[4]), .i_clock_count_fault(faults[3]),
    .i_converter_saturation_fault(faults[2]), .i_converter_range_fault(faults[1]),
    .i_analog_core_supply_fault(faults[0]), .o_alert(alert));

  task automatic report_and_stop();
    if (fail_count == 0 && checks_done > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic check(input string nm, input logic [DATA_W-1:0] seen,
                       input logic [DATA_W-1:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fail_count++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic rd(input logic [ADDR_W-1:0] a, input int exp);
    logic [DATA_W-1:0] q;
    logic v;
    host.access(1'b0, a, 16'h0000, q, v);
    check("read valid", {15'h0000, v}, 16'h0001);
    check($sformatf("register %h", a), q, 16'(exp));
  endtask

  task automatic wr_reg(input logic [ADDR_W-1:0] a, input int d);
    logic [DATA_W-1:0] q;
    logic v;
    host.access(1'b1, a, 16'(d), q, v);
    if (a == ADDR_ALERT_FLAGS) alert_m &= ~d;
  endtask

  initial begin
    repeat (20000) @(posedge i_core_clk);
    fail_count++;
    report_and_stop();
  end

  initial begin
    {cmp, deb, cv, cch, cdat, dv, dslot, ddat, dsel, cal_done, cal_err, faults} = '0;
    alert_m = 16'h8000;
    void'($urandom(39597));
    repeat (4) @(posedge i_core_clk);
    @(negedge i_core_clk) i_resetn = 1'b1;
    check("alert pin", {15'h0000, alert}, 16'h0001);
    host.early_ok = 1'b1;
    rd(ADDR_INPUT_STATES, 0);
    alert_m = 16'hC000;
    for (int i = 1; i < 10; i++) rd(8'(ADDR_INPUT_STATES + i), i == 9 ? alert_m : 0);
    cal_done = 1'b1;
    host.early_ok = 1'b0;
    wr_reg(ADDR_ALERT_FLAGS, 16'h4000);
    rd(ADDR_ALERT_FLAGS, alert_m);
    wr_reg(ADDR_ALERT_FLAGS, 16'h8000);
    rd(ADDR_ALERT_FLAGS, alert_m);
    check("alert pin", {15'h0000, alert}, 16'h0000);
    for (int b = 0; b < 5; b++) begin
      @(negedge i_core_clk) faults = 5'(1 << b);
      @(negedge i_core_clk) faults = 5'h00;
      alert_m |= 1 << (9 + b);
      rd(ADDR_ALERT_FLAGS, alert_m);
      check("alert pin", {15'h0000, alert}, 16'h0001);
      wr_reg(ADDR_ALERT_FLAGS, 0);
      rd(ADDR_ALERT_FLAGS, alert_m);
      wr_reg(ADDR_ALERT_FLAGS, alert_m);
      rd(ADDR_ALERT_FLAGS, alert_m);
    end
    @(negedge i_core_clk) cal_err = 1'b1;
    wr_reg(ADDR_ALERT_FLAGS, 16'h4000);
    alert_m = 16'h4000;
    rd(ADDR_ALERT_FLAGS, alert_m);
    cal_err = 1'b0;
    wr_reg(ADDR_ALERT_FLAGS, 16'h4000);
    rd(ADDR_ALERT_FLAGS, alert_m);
    for (int i = 0; i < 4; i++) begin
      conv_m[i] = $urandom & 16'hFFFF;
      diag_m[i] = $urandom & 16'hFFFF;
      @(negedge i_core_clk) {cv, cch, cdat} = {1'b1, 2'(i), 16'(conv_m[i])};
      {dv, dslot, ddat} = {1'b1, 2'(i), 16'(diag_m[i])};
      @(negedge i_core_clk) {cv, dv} = 2'b00;
      rd(8'(ADDR_CONV_BASE + i), conv_m[i]);
      rd(8'(ADDR_DIAG_BASE + i), diag_m[i]);
      wr_reg(8'(ADDR_CONV_BASE + i), $urandom);
      wr_reg(8'(ADDR_DIAG_BASE + i), $urandom);
    end
    for (int i = 0; i < 4; i++) begin
      rd(8'(ADDR_CONV_BASE + i), conv_m[i]);
      rd(8'(ADDR_DIAG_BASE + i), diag_m[i]);
    end
    rd(8'h30, 0);
    for (int c = 0; c < 16; c++) begin
      @(negedge i_core_clk) dsel = {4{4'(c)}};
      @(negedge i_core_clk) check("diag source", dsrc, {4{c == 15 ? 4'h0 : 4'(c)}});
    end
    cmp = 4'($urandom);
    repeat (3) @(negedge i_core_clk);
    din_m = cmp;
    rd(ADDR_INPUT_STATES, din_m);
    deb = 16'h0002;
    @(negedge i_core_clk) cmp[0] = ~cmp[0];
    // channel A needs two 250-cycle ticks before the new level shows
    repeat (240) @(negedge i_core_clk);
    rd(ADDR_INPUT_STATES, din_m);
    repeat (270) @(negedge i_core_clk);
    din_m = cmp;
    rd(ADDR_INPUT_STATES, din_m);
    // a second reset mid-run must restore the reset-seen flag and clear results
    @(negedge i_core_clk) i_resetn = 1'b0;
    @(negedge i_core_clk) i_resetn = 1'b1;
    alert_m = 16'h8000;
    check("alert pin", {15'h0000, alert}, 16'h0001);
    rd(ADDR_ALERT_FLAGS, alert_m);
    rd(ADDR_CONV_BASE, 0);
    rd(ADDR_DIAG_BASE, 0);
    report_and_stop();
  end
endmodule // tb
